/* rtl/ocp_defs.vh */
// Purpose: Constants of the overcurrent and over-temperature protection block
// Assumes: Included by every design file of the block except the synchroniser, and by the checker and the bench
// Notes: Command codes, field positions, reset values and timing counts
`ifndef OCP_DEFS_VH
`define OCP_DEFS_VH

// ==========================================================================
// Command codes
`define OCP_CMD_CLEAR 8'h03
`define OCP_CMD_PHASE 8'h04
`define OCP_CMD_OC_RESP 8'h47
`define OCP_CMD_OC_WARN 8'h4A
`define OCP_CMD_OT_LIMIT 8'h4F

// ==========================================================================
// Response register fields
`define OCP_MODE_HI 7
`define OCP_MODE_LO 6
`define OCP_RETRY_HI 5
`define OCP_RETRY_LO 3
`define OCP_DELAY_HI 2
`define OCP_DELAY_LO 0
`define OCP_MODE_IGNORE 2'h0
`define OCP_MODE_NOW 2'h3
`define OCP_RETRY_NONE 3'h0
`define OCP_RETRY_ALWAYS 3'h7

// ==========================================================================
// Linear-format fields and the highest phase number
`define OCP_MANT_HI 10
`define OCP_MANT_LO 0
`define OCP_PHASE_MAX 8'h03

// ==========================================================================
// Reset values
`define OCP_RST_RESP 8'h80
`define OCP_RST_PHASE 2'h0
`define OCP_RST_WARN 16'hF0A0
`define OCP_RST_OT 16'h007D

// ==========================================================================
// Hardware grid of the warning threshold, in 0.25 A units, and the over-temperature off code
`define OCP_HW_MIN 11'h020
`define OCP_HW_MAX 11'h0F8
`define OCP_HW_STEP_MASK 11'h7F8
`define OCP_OT_OFF 11'h0FF

// ==========================================================================
// Timing
`define OCP_DLY_SHORT 3'h1
`define OCP_DLY_MID 3'h3
`define OCP_DLY_LONG 3'h7
`define OCP_CLK_MHZ 25
`define OCP_SOFT_START_US 1000

`endif

/* rtl/ocp_sync.v */
// Purpose: Three-stage synchroniser for one pin input
// Assumes: Input is asynchronous to clk_in
// Notes: Output changes only when stages two and three agree
`timescale 1ns/100ps
module ocp_sync (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire async_in,
  output reg level_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_out <= 1'b0;
    end else if (ce_in) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end
endmodule // ocp_sync

/* rtl/ocp_phase_warn.v */
// Purpose: One phase's overcurrent warning threshold and comparator
// Assumes: Write strobe is already qualified by the phase selection
// Notes: Threshold applied in hardware is clamped and quantised
`timescale 1ns/100ps
`include "ocp_defs.vh"
module ocp_phase_warn (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire wr_in,
  input wire [15:0] wdata_in,
  input wire [15:0] iout_in,
  input wire iout_valid_in,
  output wire [15:0] thr_out,
  output reg warn_out
);
  reg [15:0] thr_q;
  reg [10:0] applied;
  wire [10:0] prog_mant;

  assign thr_out = thr_q;
  assign prog_mant = thr_q[`OCP_MANT_HI:`OCP_MANT_LO];

  // Clamp to the hardware range, then snap down to the 2 A grid
  always @* begin
    if (prog_mant < `OCP_HW_MIN) begin
      applied = `OCP_HW_MIN; // [R9]
    end else if (prog_mant > `OCP_HW_MAX) begin
      applied = `OCP_HW_MAX; // [R9]
    end else begin
      applied = prog_mant & `OCP_HW_STEP_MASK; // [R9]
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      thr_q <= `OCP_RST_WARN;
      warn_out <= 1'b0;
    end else if (ce_in) begin
      if (wr_in) begin
        thr_q <= wdata_in; // [R8]
      end
      if (iout_valid_in) begin
        warn_out <= (iout_in[`OCP_MANT_HI:`OCP_MANT_LO] >= applied); // [R5]
      end
    end
  end
endmodule // ocp_phase_warn

/* rtl/ocp_protect.v */
// Purpose: Overcurrent and over-temperature protection settings and response
// Assumes: Measurements arrive on clk_in; comparator and switching clock are pins
// Notes: Registers are reached through the command port by command code
//
// Behaviour
// [R1] Retry codes 4, 5 and 6 allow that many restarts, then latch off until reset.
// [R2] Retry code 7 retries without limit until commanded off or another fault stops it.
// [R3] Delay codes 0-1 give 1, 2-4 give 3 and 5-7 give 7 switching-clock periods of delay.
// [R4] The restart wait is one soft-start time for codes 0-1, else code times soft-start.
// [R5] A phase warns when its measured current reaches its warning threshold.
// [R6] Each phase keeps and reports its own warning independently.
// [R7] The host selects phase 0 to 3 first, and only that phase's threshold is written.
// [R8] The warning threshold is a 16-bit linear value with 0.25 A resolution.
// [R9] The applied threshold is clamped to 8-62 A and quantised to 2 A steps.
// [R10] The over-temperature limit is linear in degrees and faults when exceeded.
// [R11] A limit of 255 degrees turns off the programmable over-temperature check.
// [R12] Every response mode pulls the alert line low and sets the fault flag.
// [R13] Retry code 0 makes no restart and holds the output off until faults are cleared.
// [R14] Each failed restart is counted and followed by the wait; exhaustion latches off.
`timescale 1ns/100ps
`include "ocp_defs.vh"
module ocp_protect #(
  parameter SOFT_START_CYC = `OCP_SOFT_START_US * `OCP_CLK_MHZ
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire ce_in,
  input wire cmd_valid_in,
  input wire cmd_write_in,
  input wire [7:0] cmd_code_in,
  input wire [15:0] cmd_wdata_in,
  output reg [15:0] cmd_rdata_out,
  output reg cmd_ack_out,
  output reg cmd_nak_out,
  input wire pwm_clk_in,
  input wire oc_comp_in,
  input wire output_on_cmd_in,
  input wire other_fault_in,
  input wire [63:0] iout_meas_in,
  input wire iout_valid_in,
  input wire [15:0] temp_meas_in,
  input wire temp_valid_in,
  output reg output_enable_out,
  output reg alert_n_out,
  output reg oc_fault_out,
  output reg ot_fault_out,
  output wire [3:0] oc_warn_out,
  output reg [2:0] retry_count_out,
  output reg latched_off_out
);

  // ========================================================================
  // States
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_WAIT = 3'h3;
  localparam [2:0] ST_SOFT = 3'h4;
  localparam [2:0] ST_LATCH = 3'h5;

  // ========================================================================
  // Declarations
  reg [7:0] resp_q;
  reg [1:0] phase_q;
  reg [15:0] ot_limit_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] dly_cnt_q;
  reg [2:0] dly_cnt_d;
  reg [31:0] ss_cnt_q;
  reg [31:0] ss_cnt_d;
  reg [2:0] mult_cnt_q;
  reg [2:0] mult_cnt_d;
  reg [2:0] tries_q;
  reg [2:0] tries_d;
  reg clr_ok_q;
  reg clr_ok_d;
  reg pwm_prev_q;
  reg [2:0] dly_len;
  reg [2:0] wait_mult;
  reg cmd_known;
  reg [15:0] rd_mux;
  wire pwm_lvl;
  wire oc_lvl;
  wire pwm_rise;
  wire [1:0] mode;
  wire [2:0] retry;
  wire [2:0] dcode;
  wire wr_en;
  wire clr_evt;
  wire ot_hit;
  wire [63:0] thr_all;
  wire [15:0] sel_thr;
  wire shut_retry;

  // ========================================================================
  // Pin synchronisers
  ocp_sync u_sync_pwm (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in(pwm_clk_in),
    .level_out(pwm_lvl)
  );

  ocp_sync u_sync_oc (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .async_in(oc_comp_in),
    .level_out(oc_lvl)
  );

  assign pwm_rise = pwm_lvl & ~pwm_prev_q;

  // ========================================================================
  // Per-phase warning thresholds
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_phase
      ocp_phase_warn u_warn (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .wr_in(wr_en && (cmd_code_in == `OCP_CMD_OC_WARN) && (phase_q == gi)), // [R7]
        .wdata_in(cmd_wdata_in),
        .iout_in(iout_meas_in[gi*16 +: 16]),
        .iout_valid_in(iout_valid_in),
        .thr_out(thr_all[gi*16 +: 16]),
        .warn_out(oc_warn_out[gi]) // [R6]
      );
    end
  endgenerate

  assign sel_thr = thr_all[phase_q*16 +: 16];

  // ========================================================================
  // Command port
  assign wr_en = cmd_valid_in & cmd_write_in & cmd_known;
  assign clr_evt = wr_en && (cmd_code_in == `OCP_CMD_CLEAR);

  always @* begin
    cmd_known = 1'b1;
    rd_mux = 16'h0000;
    case (cmd_code_in)
      `OCP_CMD_CLEAR: rd_mux = 16'h0000;
      `OCP_CMD_PHASE: rd_mux = {14'h0000, phase_q};
      `OCP_CMD_OC_RESP: rd_mux = {8'h00, resp_q};
      `OCP_CMD_OC_WARN: rd_mux = sel_thr;
      `OCP_CMD_OT_LIMIT: rd_mux = ot_limit_q;
      default: cmd_known = 1'b0;
    endcase
    if (cmd_write_in && (cmd_code_in == `OCP_CMD_PHASE) &&
        (cmd_wdata_in[7:0] > `OCP_PHASE_MAX)) begin
      cmd_known = 1'b0; // [R7]
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      resp_q <= `OCP_RST_RESP;
      phase_q <= `OCP_RST_PHASE;
      ot_limit_q <= `OCP_RST_OT;
      cmd_rdata_out <= 16'h0000;
      cmd_ack_out <= 1'b0;
      cmd_nak_out <= 1'b0;
    end else if (ce_in) begin
      cmd_ack_out <= cmd_valid_in & cmd_known;
      cmd_nak_out <= cmd_valid_in & ~cmd_known;
      if (cmd_valid_in && !cmd_write_in && cmd_known) begin
        cmd_rdata_out <= rd_mux;
      end
      if (wr_en) begin
        case (cmd_code_in)
          `OCP_CMD_PHASE: phase_q <= cmd_wdata_in[1:0]; // [R7]
          `OCP_CMD_OC_RESP: resp_q <= cmd_wdata_in[7:0];
          `OCP_CMD_OT_LIMIT: ot_limit_q <= cmd_wdata_in; // [R10]
          default: resp_q <= resp_q;
        endcase
      end
    end
  end

  // ========================================================================
  // Over-temperature check
  assign ot_hit = temp_valid_in &&
                  (ot_limit_q[`OCP_MANT_HI:`OCP_MANT_LO] != `OCP_OT_OFF) && // [R11]
                  ($signed(temp_meas_in[`OCP_MANT_HI:`OCP_MANT_LO]) >
                   $signed(ot_limit_q[`OCP_MANT_HI:`OCP_MANT_LO])); // [R10]

  // ========================================================================
  // Response decode
  assign mode = resp_q[`OCP_MODE_HI:`OCP_MODE_LO];
  assign retry = resp_q[`OCP_RETRY_HI:`OCP_RETRY_LO];
  assign dcode = resp_q[`OCP_DELAY_HI:`OCP_DELAY_LO];

  always @* begin
    if (dcode < 3'h2) begin
      dly_len = `OCP_DLY_SHORT; // [R3]
      wait_mult = 3'h1; // [R4]
    end else if (dcode < 3'h5) begin
      dly_len = `OCP_DLY_MID; // [R3]
      wait_mult = dcode; // [R4]
    end else begin
      dly_len = `OCP_DLY_LONG; // [R3]
      wait_mult = dcode; // [R4]
    end
  end

  // Another restart is allowed when retries remain or retry is unlimited
  assign shut_retry = (retry == `OCP_RETRY_ALWAYS) || (tries_q < retry); // [R1] [R2]

  // ========================================================================
  // Fault response state machine
  always @* begin
    state_d = state_q;
    dly_cnt_d = dly_cnt_q;
    ss_cnt_d = ss_cnt_q;
    mult_cnt_d = mult_cnt_q;
    tries_d = tries_q;
    clr_ok_d = clr_ok_q;
    case (state_q)
      ST_OFF: begin
        tries_d = 3'h0;
        if (output_on_cmd_in && !other_fault_in) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (oc_lvl && mode != `OCP_MODE_IGNORE) begin
          dly_cnt_d = 3'h0;
          state_d = (mode == `OCP_MODE_NOW) ? ST_WAIT : ST_DELAY; // [R12]
        end
      end
      ST_DELAY: begin
        if (pwm_rise) begin
          dly_cnt_d = dly_cnt_q + 3'h1;
          if (dly_cnt_q + 3'h1 >= dly_len) begin
            state_d = ST_WAIT; // [R3]
          end
        end
      end
      ST_WAIT: begin
        if (ss_cnt_q + 32'h0000_0001 >= SOFT_START_CYC) begin
          ss_cnt_d = 32'h0000_0000;
          mult_cnt_d = mult_cnt_q + 3'h1;
          if (mult_cnt_q + 3'h1 >= wait_mult) begin
            mult_cnt_d = 3'h0;
            state_d = ST_SOFT; // [R4] [R14]
            tries_d = tries_q + 3'h1; // [R14]
          end
        end else begin
          ss_cnt_d = ss_cnt_q + 32'h0000_0001;
        end
      end
      ST_SOFT: begin
        if (oc_lvl) begin
          ss_cnt_d = 32'h0000_0000;
          state_d = ST_WAIT; // [R14]
        end else if (ss_cnt_q + 32'h0000_0001 >= SOFT_START_CYC) begin
          ss_cnt_d = 32'h0000_0000;
          tries_d = 3'h0;
          state_d = ST_RUN;
        end else begin
          ss_cnt_d = ss_cnt_q + 32'h0000_0001;
        end
      end
      ST_LATCH: begin
        if (clr_ok_q && clr_evt) begin
          state_d = ST_OFF; // [R13]
        end
      end
      default: state_d = ST_OFF;
    endcase
    // Entering the wait decides between another restart and latching off
    if (state_d == ST_WAIT && state_q != ST_WAIT) begin
      ss_cnt_d = 32'h0000_0000;
      mult_cnt_d = 3'h0;
      if (retry == `OCP_RETRY_NONE) begin
        state_d = ST_LATCH; // [R13]
        clr_ok_d = 1'b1;
      end else if (!shut_retry) begin
        state_d = ST_LATCH; // [R1] [R14]
        clr_ok_d = 1'b0;
      end
    end
    // Commanded off or another fault ends any restart sequence
    if (state_q != ST_LATCH && (!output_on_cmd_in || other_fault_in)) begin
      state_d = ST_OFF; // [R2]
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_OFF;
      dly_cnt_q <= 3'h0;
      ss_cnt_q <= 32'h0000_0000;
      mult_cnt_q <= 3'h0;
      tries_q <= 3'h0;
      clr_ok_q <= 1'b0;
      pwm_prev_q <= 1'b0;
      output_enable_out <= 1'b0;
      latched_off_out <= 1'b0;
      retry_count_out <= 3'h0;
    end else if (ce_in) begin
      state_q <= state_d;
      dly_cnt_q <= dly_cnt_d;
      ss_cnt_q <= ss_cnt_d;
      mult_cnt_q <= mult_cnt_d;
      tries_q <= tries_d;
      clr_ok_q <= clr_ok_d;
      pwm_prev_q <= pwm_lvl;
      output_enable_out <= (state_d == ST_RUN) || (state_d == ST_DELAY) ||
                           (state_d == ST_SOFT);
      latched_off_out <= (state_d == ST_LATCH); // [R1]
      retry_count_out <= tries_d; // [R14]
    end
  end

  // ========================================================================
  // Sticky fault flags and alert line; a new event wins over a clear
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      oc_fault_out <= 1'b0;
      ot_fault_out <= 1'b0;
      alert_n_out <= 1'b1;
    end else if (ce_in) begin
      oc_fault_out <= oc_lvl | (oc_fault_out & ~clr_evt); // [R12]
      ot_fault_out <= ot_hit | (ot_fault_out & ~clr_evt); // [R10]
      alert_n_out <= ~(oc_lvl | ot_hit | ((oc_fault_out | ot_fault_out) & ~clr_evt)); // [R12]
    end
  end

endmodule // ocp_protect

/* test/ocp_protect_checker.sv */
// Purpose: Port-level assertions of the protection block
// Assumes: Bound to the top module of the block
// Notes: Tracks response and limit settings from accepted writes
`timescale 1ns/100ps
`include "ocp_defs.vh"
module ocp_protect_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  input wire logic cmd_ack_out,
  input wire logic cmd_nak_out,
  input wire logic output_on_cmd_in,
  input wire logic other_fault_in,
  input wire logic [15:0] temp_meas_in,
  input wire logic temp_valid_in,
  input wire logic output_enable_out,
  input wire logic alert_n_out,
  input wire logic oc_fault_out,
  input wire logic ot_fault_out,
  input wire logic [2:0] retry_count_out,
  input wire logic latched_off_out
);
  logic [7:0] resp_q;
  logic [15:0] ot_q;
  wire wr = ce_in && cmd_valid_in && cmd_write_in;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      resp_q <= `OCP_RST_RESP;
      ot_q <= `OCP_RST_OT;
    end else begin
      if (wr && cmd_code_in == `OCP_CMD_OC_RESP) resp_q <= cmd_wdata_in[7:0];
      if (wr && cmd_code_in == `OCP_CMD_OT_LIMIT) ot_q <= cmd_wdata_in;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_cmd_answer_once: assert property (ce_in && cmd_valid_in |=> cmd_ack_out != cmd_nak_out)
    else $error("command not answered exactly once");
  a_phase_refused: assert property (wr && cmd_code_in == `OCP_CMD_PHASE
    && cmd_wdata_in[7:0] > `OCP_PHASE_MAX |=> cmd_nak_out) else $error("bad phase accepted");
  a_latch_dark: assert property (latched_off_out |-> !output_enable_out)
    else $error("output on while latched");
  a_alert_flags: assert property (oc_fault_out || ot_fault_out |-> !alert_n_out)
    else $error("alert high with fault flag");
  a_retry_cap: assert property (resp_q[5:3] != 3'h7 |-> retry_count_out <= resp_q[5:3])
    else $error("too many restarts");
  a_latch_hold: assert property (latched_off_out && resp_q[5:3] != 3'h0
    |=> latched_off_out) else $error("latch released before reset");
  a_ot_detect: assert property (temp_valid_in && ce_in && ot_q[10:0] != `OCP_OT_OFF
    && $signed(temp_meas_in[10:0]) > $signed(ot_q[10:0]) |-> ##[1:2] ot_fault_out)
    else $error("over-temperature missed");
  a_ot_disabled: assert property (ot_q[10:0] == `OCP_OT_OFF
    && $past(ot_q[10:0]) == `OCP_OT_OFF && !ot_fault_out |=> !ot_fault_out)
    else $error("disabled limit raised fault");
  a_fast_off: assert property (resp_q[7:6] == 2'h3 && $rose(oc_fault_out)
    |-> ##[0:2] !output_enable_out) else $error("no immediate shutdown");
  a_ignore_runs: assert property (resp_q[7:6] == 2'h0 && output_enable_out
    && output_on_cmd_in && !other_fault_in |=> output_enable_out)
    else $error("ignored fault stopped output");
endmodule // ocp_protect_checker

/* test/ocp_host.sv */
// Purpose: Host model for the command port and the switching clock
// Assumes: Requests launched at the falling clock edge
// Notes: Switching clock runs free with a 320 ns period
`timescale 1ns/100ps
module ocp_host (
  input wire clk_in,
  input wire ack_in,
  output reg valid_out = 1'b0,
  output reg write_out = 1'b0,
  output reg [7:0] code_out = 8'h00,
  output reg [15:0] wdata_out = 16'h0000,
  output reg pwm_out = 1'b0
);
  always #160 pwm_out = ~pwm_out;
  // One-cycle request; answer read in the cycle after it is taken
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output logic ok);
    @(negedge clk_in);
    valid_out = 1'b1;
    write_out = w;
    code_out = c;
    wdata_out = d;
    @(negedge clk_in);
    valid_out = 1'b0;
    write_out = ~w;
    code_out = ~c;
    wdata_out = ~d;
    ok = ack_in;
  endtask
endmodule // ocp_host

/* test/tb.sv */
// Purpose: Self-checking bench of the protection block
// Assumes: Soft-start count shortened to 8 cycles
// Notes: Inputs change at the falling clock edge
`timescale 1ns/100ps
`include "ocp_defs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
  localparam SS = 8;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic oc_comp_in = 1'b0;
  logic output_on_cmd_in = 1'b1;
  logic other_fault_in = 1'b0;
  logic [63:0] iout_meas_in = 64'h0;
  logic iout_valid_in = 1'b0;
  logic [15:0] temp_meas_in = 16'h0;
  logic temp_valid_in = 1'b0;
  wire cmd_valid_in, cmd_write_in, cmd_ack_out, cmd_nak_out, pwm_clk_in, output_enable_out;
  wire alert_n_out, oc_fault_out, ot_fault_out, latched_off_out;
  wire [7:0] cmd_code_in;
  wire [15:0] cmd_wdata_in, cmd_rdata_out;
  wire [3:0] oc_warn_out;
  wire [2:0] retry_count_out;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  always #20 clk_in = ~clk_in;
  ocp_host host (.clk_in(clk_in), .ack_in(cmd_ack_out), .valid_out(cmd_valid_in),
    .write_out(cmd_write_in), .code_out(cmd_code_in), .wdata_out(cmd_wdata_in),
    .pwm_out(pwm_clk_in));
  ocp_protect #(.SOFT_START_CYC(SS)) dut (.*);
  task automatic test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (6) @(negedge clk_in);
  endtask
  task automatic rw(input logic w, input logic [7:0] c, input logic [15:0] d, input logic ok_x,
    input logic [15:0] rd_x);
    logic ok;
    host.xfer(w, c, d, ok);
    `CHK(ok, ok_x)
    `CHK(cmd_nak_out, ce_in && !ok_x)
    if (!w) `CHK(cmd_rdata_out, rd_x)
  endtask
  task automatic put_temp(input logic [15:0] t);
    temp_meas_in = t;
    temp_valid_in = 1'b1;
    @(negedge clk_in);
    temp_valid_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic t_regs();
    rw(1'b0, `OCP_CMD_OC_RESP, 16'h0, 1'b1, 16'h0080);
    rw(1'b0, `OCP_CMD_OC_WARN, 16'h0, 1'b1, 16'hF0A0);
    rw(1'b0, `OCP_CMD_OT_LIMIT, 16'h0, 1'b1, 16'h007D);
    rw(1'b1, 8'h55, 16'h0, 1'b0, 16'h0);
    rw(1'b1, `OCP_CMD_PHASE, 16'h0004, 1'b0, 16'h0);
    // A frozen block neither answers nor stores
    @(negedge clk_in);
    ce_in = 1'b0;
    rw(1'b1, `OCP_CMD_PHASE, 16'h0002, 1'b0, 16'h0);
    ce_in = 1'b1;
    rw(1'b0, `OCP_CMD_PHASE, 16'h0, 1'b1, 16'h0000);
    $display("regs done");
  endtask
  task automatic t_warn();
    rw(1'b1, `OCP_CMD_PHASE, 16'h0001, 1'b1, 16'h0);
    rw(1'b1, `OCP_CMD_OC_WARN, 16'h0040, 1'b1, 16'h0);
    rw(1'b1, `OCP_CMD_PHASE, 16'h0002, 1'b1, 16'h0);
    rw(1'b1, `OCP_CMD_OC_WARN, 16'h0010, 1'b1, 16'h0);
    rw(1'b1, `OCP_CMD_PHASE, 16'h0003, 1'b1, 16'h0);
    rw(1'b1, `OCP_CMD_OC_WARN, 16'h0045, 1'b1, 16'h0);
    rw(1'b0, `OCP_CMD_OC_WARN, 16'h0, 1'b1, 16'h0045);
    iout_meas_in = {16'h0040, 16'h0020, 16'h003F, 16'h009F};
    repeat (2) begin
      iout_valid_in = 1'b1;
      @(negedge clk_in);
      iout_valid_in = 1'b0;
      @(negedge clk_in);
      `CHK(oc_warn_out, {3'b110, iout_meas_in[7:0] == 8'hA0})
      iout_meas_in[15:0] = 16'h00A0;
    end
    $display("warn done");
  endtask
  task automatic t_ot();
    rw(1'b1, `OCP_CMD_OT_LIMIT, 16'h0050, 1'b1, 16'h0);
    put_temp(16'h0050);
    `CHK(ot_fault_out, 1'b0)
    put_temp(16'h0051);
    `CHK(ot_fault_out, 1'b1)
    `CHK(alert_n_out, 1'b0)
    rw(1'b1, `OCP_CMD_OT_LIMIT, 16'h00FF, 1'b1, 16'h0);
    rw(1'b1, `OCP_CMD_CLEAR, 16'h0, 1'b1, 16'h0);
    // Above the disabling code itself, so only the off decode keeps it quiet
    put_temp(16'h012C);
    `CHK(ot_fault_out, 1'b0)
    $display("ot done");
  endtask
  task automatic t_ignore();
    do_reset();
    rw(1'b1, `OCP_CMD_OC_RESP, 16'h0000, 1'b1, 16'h0);
    oc_comp_in = 1'b1;
    repeat (40) @(negedge clk_in);
    `CHK(output_enable_out, 1'b1)
    `CHK(oc_fault_out, 1'b1)
    oc_comp_in = 1'b0;
    $display("ignore done");
  endtask
  task automatic t_delay(input logic [2:0] d);
    int cnt;
    int p;
    p = (d < 2) ? 1 : (d < 5) ? 3 : 7;
    do_reset();
    rw(1'b1, `OCP_CMD_OC_RESP, {8'h00, 2'h2, 3'h0, d}, 1'b1, 16'h0);
    `CHK(output_enable_out, 1'b1)
    oc_comp_in = 1'b1;
    cnt = 0;
    while (output_enable_out === 1'b1 && cnt < 200) begin
      @(negedge clk_in);
      cnt++;
    end
    `CHK(cnt > p * 8 - 6 && cnt <= p * 8 + 9, 1'b1)
    oc_comp_in = 1'b0;
    $display("delay %0d done", d);
  endtask
  task automatic t_retry(input logic [2:0] n);
    int rises;
    int gap;
    int mult;
    logic prev;
    mult = (n < 2) ? 1 : n;
    rises = 0;
    gap = 0;
    prev = 1'b1;
    do_reset();
    rw(1'b1, `OCP_CMD_OC_RESP, {8'h00, 2'h0, 3'h3, n}, 1'b1, 16'h0);
    rw(1'b1, `OCP_CMD_OC_RESP, {8'h00, 2'h3, n, n}, 1'b1, 16'h0);
    oc_comp_in = 1'b1;
    repeat (700) begin
      @(negedge clk_in);
      if (output_enable_out === 1'b1 && !prev) begin
        rises++;
        `CHK(gap >= mult * SS && gap <= mult * SS + 2, 1'b1)
      end
      gap = (output_enable_out === 1'b1) ? 0 : gap + 1;
      prev = (output_enable_out === 1'b1);
    end
    if (n == 3'h7) begin
      `CHK(rises >= 8, 1'b1)
      other_fault_in = 1'b1;
      repeat (4) @(negedge clk_in);
      `CHK(output_enable_out, 1'b0)
      other_fault_in = 1'b0;
    end else begin
      `CHK(rises == n, 1'b1)
      `CHK(retry_count_out, n)
      `CHK(latched_off_out, 1'b1)
      oc_comp_in = 1'b0;
      repeat (8) @(negedge clk_in);
      rw(1'b1, `OCP_CMD_CLEAR, 16'h0, 1'b1, 16'h0);
      `CHK(latched_off_out, n != 3'h0)
    end
    oc_comp_in = 1'b0;
    $display("retry %0d done", n);
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    do_reset();
    t_regs();
    t_warn();
    t_ot();
    t_ignore();
    for (int d = 0; d < 8; d++) t_delay(3'(d));
    for (int n = 0; n < 8; n++) t_retry(3'(n));
    test_done();
  end
endmodule // tb
bind ocp_protect ocp_protect_checker chk (.*);
